/* File: rtl/clkout_cfg.svh */
// constants of the programmable clock output generator
// assumes a single 20 MHz clock and a 12-bit nibble-wide data memory write port
`ifndef CLKOUT_CFG_SVH
`define CLKOUT_CFG_SVH

// ************************************************************
// register map
// ************************************************************
`define CLKOUT_MODE_ADDR    12'hfd0
`define CLKOUT_MODE_RESET   4'h0
`define CLKOUT_EN_BIT       3
`define CLKOUT_RSVD_BIT     2
`define CLKOUT_SEL_HI_BIT   1
`define CLKOUT_SEL_LO_BIT   0

// ************************************************************
// timing
// ************************************************************
`define CLKOUT_OSC_DIV      3
`define CLKOUT_SWITCH_MC    4
`define CLKOUT_OSC_STOP_MC  32
`define CLKOUT_SUB_DIV_BIT  1

`endif

/* File: rtl/clkout_pkg.sv */
// types of the programmable clock output generator
// assumes clkout_cfg.svh is included by the users of the constants
package clkout_pkg;

    // output source select codes
    typedef enum logic [1:0] {
        CLKOUT_SRC_CPU   = 2'b00,
        CLKOUT_SRC_DIV8  = 2'b01,
        CLKOUT_SRC_DIV16 = 2'b10,
        CLKOUT_SRC_DIV64 = 2'b11
    } clkout_src_t;

    // cpu clock divider codes
    typedef enum logic [1:0] {
        CLKOUT_CPU_DIV64 = 2'b00,
        CLKOUT_CPU_DIV16 = 2'b01,
        CLKOUT_CPU_DIV8  = 2'b10,
        CLKOUT_CPU_DIV4  = 2'b11
    } clkout_cpu_div_t;

    // pin gate state
    typedef enum logic [0:0] {
        CLKOUT_GATE_OFF = 1'b0,
        CLKOUT_GATE_ON  = 1'b1
    } clkout_gate_t;

endpackage : clkout_pkg

/* File: rtl/clkout_tick.sv */
// prescaler: one-cycle tick every DIV clocks, modelling the main oscillator rate
// assumes a free running clock
`timescale 1ns/1ns
module clkout_tick #(
    parameter int DIV = 3
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // tick out
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CW-1:0] cnt_ff;

    if (DIV < 1) begin : g_bad_div
        $error("clkout_tick: DIV must be at least 1");
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= '0;
        end else if (cnt_ff == CW'(DIV - 1)) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    assign tick = (cnt_ff == CW'(DIV - 1));

endmodule : clkout_tick

/* File: rtl/clkout_gen.sv */
// programmable clock output generator: mode register, cpu clock with delayed
// switchover, source select and glitch-free gate onto the shared port pin
// assumes synchronous inputs, the port latch and port mode held outside
`timescale 1ns/1ns
`include "clkout_cfg.svh"
module clkout_gen
    import clkout_pkg::*;
#(
    parameter int OSC_DIV   = `CLKOUT_OSC_DIV,
    parameter int SWITCH_MC = `CLKOUT_SWITCH_MC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // data memory port
    input  wire logic        mem_wr,
    input  wire logic        mem_rd,
    input  wire logic [11:0] mem_addr,
    input  wire logic [3:0]  mem_wdata,
    output logic      [3:0]  mem_rdata,
    // clock generator settings
    input  wire logic [1:0]  processor_clock_control,
    input  wire logic        system_clock_control,
    input  wire logic        sub_osc_in,
    // cpu clock outputs
    output logic             cpu_clock,
    output logic             machine_cycle,
    output logic             cpu_on_subsystem,
    // shared port pin
    input  wire logic        port2_line2_latch,
    input  wire logic        port2_line2_out_mode,
    output logic             clock_out_pin,
    output logic             port2_line2_out,
    output logic             port2_line2_oe
);

    // the counters below cannot serve these values
    if (OSC_DIV < 1) begin : g_bad_osc_div
        $error("clkout_gen: OSC_DIV must be at least 1");
    end
    if (SWITCH_MC < 1 || SWITCH_MC > 255) begin : g_bad_switch_mc
        $error("clkout_gen: SWITCH_MC out of range");
    end

    // ************************************************************
    // main oscillator phase
    // ************************************************************
    logic       osc_tick;
    logic [5:0] phase_ff;

    clkout_tick #(
        .DIV (OSC_DIV)
    ) u_tick (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (osc_tick)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_ff <= 6'h00;
        end else if (osc_tick) begin
            phase_ff <= phase_ff + 6'h01;
        end
    end

    // bit n of the phase is a square wave at the oscillator rate / 2^(n+1)
    function automatic logic osc_div_level(input logic [5:0] ph, input logic [1:0] code);
        logic lvl;
        lvl = 1'b0;
        unique case (code)
            2'b00: lvl = ph[1];
            2'b01: lvl = ph[2];
            2'b10: lvl = ph[3];
            2'b11: lvl = ph[5];
        endcase
        return lvl;
    endfunction : osc_div_level

    // ************************************************************
    // subsystem clock divided by four
    // ************************************************************
    logic       sub_q_ff;
    logic [1:0] sub_cnt_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sub_q_ff <= 1'b0;
        end else begin
            sub_q_ff <= sub_osc_in;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sub_cnt_ff <= 2'h0;
        end else if (sub_osc_in && !sub_q_ff) begin
            sub_cnt_ff <= sub_cnt_ff + 2'h1;
        end
    end

    // ************************************************************
    // cpu clock with delayed switchover
    // ************************************************************
    // the cpu keeps its old clock for SWITCH_MC machine cycles after a new
    // setting appears, so a setting written mid-cycle never truncates a cycle
    logic       cpu_sub_ff;
    logic [1:0] cpu_div_ff;
    logic [7:0] sw_cnt_ff;
    logic       cpu_lvl_ff;
    logic       cpu_lvl_prev_ff;
    logic       nxt_cpu_lvl;
    logic       sw_pending;
    logic       mc_edge;

    assign sw_pending = (cpu_sub_ff != system_clock_control)
                     || (cpu_div_ff != processor_clock_control);
    assign mc_edge    = cpu_lvl_ff && !cpu_lvl_prev_ff;

    always_comb begin
        if (cpu_sub_ff) begin
            nxt_cpu_lvl = sub_cnt_ff[`CLKOUT_SUB_DIV_BIT];
        end else begin
            unique case (clkout_cpu_div_t'(cpu_div_ff))
                CLKOUT_CPU_DIV64: nxt_cpu_lvl = osc_div_level(phase_ff, 2'b11);
                CLKOUT_CPU_DIV16: nxt_cpu_lvl = osc_div_level(phase_ff, 2'b10);
                CLKOUT_CPU_DIV8:  nxt_cpu_lvl = osc_div_level(phase_ff, 2'b01);
                CLKOUT_CPU_DIV4:  nxt_cpu_lvl = osc_div_level(phase_ff, 2'b00);
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_lvl_ff      <= 1'b0;
            cpu_lvl_prev_ff <= 1'b0;
        end else begin
            cpu_lvl_ff      <= nxt_cpu_lvl;
            cpu_lvl_prev_ff <= cpu_lvl_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_cnt_ff <= 8'h00;
        end else if (!sw_pending) begin
            sw_cnt_ff <= 8'h00;
        end else if (mc_edge) begin
            sw_cnt_ff <= sw_cnt_ff + 8'h01;
        end
    end

    // apply the new setting on a machine cycle boundary only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_sub_ff <= 1'b0;
            cpu_div_ff <= 2'b00;
        end else if (sw_pending && mc_edge && sw_cnt_ff == 8'(SWITCH_MC - 1)) begin
            cpu_sub_ff <= system_clock_control;
            cpu_div_ff <= processor_clock_control;
        end
    end

    assign cpu_clock        = cpu_lvl_ff;
    assign machine_cycle    = mc_edge;
    assign cpu_on_subsystem = cpu_sub_ff;

    // ************************************************************
    // mode register
    // ************************************************************
    logic [3:0] mode_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= `CLKOUT_MODE_RESET;
        end else if (mem_wr && mem_addr == `CLKOUT_MODE_ADDR) begin
            mode_ff <= mem_wdata;
        end
    end

    // the register is write only; its address and every other one read zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_rdata <= 4'h0;
        end else if (mem_rd) begin
            mem_rdata <= 4'h0;
        end
    end

    // ************************************************************
    // source select and glitch-free gate
    // ************************************************************
    // select is taken into the mux only while the gate is off, so a select
    // written while running cannot splice two waveforms
    logic         src_lvl_ff;
    logic         nxt_src_lvl;
    logic [1:0]   sel_ff;
    clkout_gate_t gate_ff;
    logic         out_ff;
    logic         want_on;
    logic [1:0]   sel_req;

    assign want_on = mode_ff[`CLKOUT_EN_BIT];
    assign sel_req = {mode_ff[`CLKOUT_SEL_HI_BIT], mode_ff[`CLKOUT_SEL_LO_BIT]};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_ff <= 2'b00;
        end else if (gate_ff == CLKOUT_GATE_OFF) begin
            sel_ff <= sel_req;
        end
    end

    always_comb begin
        unique case (clkout_src_t'(sel_ff))
            CLKOUT_SRC_CPU:   nxt_src_lvl = cpu_lvl_ff;
            CLKOUT_SRC_DIV8:  nxt_src_lvl = osc_div_level(phase_ff, 2'b01);
            CLKOUT_SRC_DIV16: nxt_src_lvl = osc_div_level(phase_ff, 2'b10);
            CLKOUT_SRC_DIV64: nxt_src_lvl = osc_div_level(phase_ff, 2'b11);
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_lvl_ff <= 1'b0;
        end else begin
            src_lvl_ff <= nxt_src_lvl;
        end
    end

    // the gate moves only while both the current and coming source level
    // are low, so the first and last pulses are always whole
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_ff <= CLKOUT_GATE_OFF;
        end else if (!src_lvl_ff && !nxt_src_lvl) begin
            unique case (gate_ff)
                // wait for the select to settle, so a select and an enable
                // written together cannot start on a half phase
                CLKOUT_GATE_OFF: begin
                    if (want_on && sel_ff == sel_req) gate_ff <= CLKOUT_GATE_ON;
                end
                CLKOUT_GATE_ON:  if (!want_on) gate_ff <= CLKOUT_GATE_OFF;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_ff <= 1'b0;
        end else begin
            out_ff <= nxt_src_lvl && (gate_ff == CLKOUT_GATE_ON);
        end
    end

    // ************************************************************
    // shared port pin
    // ************************************************************
    // the latch must hold zero while the clock runs, otherwise the pin
    // simply stays high
    assign clock_out_pin   = out_ff;
    assign port2_line2_out = port2_line2_latch | out_ff;
    assign port2_line2_oe  = port2_line2_out_mode;

endmodule : clkout_gen

/* File: verification/clkout_chk_asserts.sv */
// port checker of the clock output generator
// assumes binding to clkout_gen, one clock domain
`timescale 1ns/1ns
`include "clkout_cfg.svh"
module clkout_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // register port
    input wire logic        mem_wr,
    input wire logic [11:0] mem_addr,
    input wire logic [3:0]  mem_wdata,
    input wire logic [3:0]  mem_rdata,
    // clock generator
    input wire logic        system_clock_control,
    input wire logic        cpu_on_subsystem,
    // pin
    input wire logic        port2_line2_latch,
    input wire logic        port2_line2_out_mode,
    input wire logic        clock_out_pin,
    input wire logic        port2_line2_out,
    input wire logic        port2_line2_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic       en_ff;
    logic       seen_ff;
    logic [7:0] off_cnt_ff;
    // ************************************************************
    // helpers: last enable written, cycles since disable
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_ff   <= 1'b0;
            seen_ff <= 1'b0;
        end else if (mem_wr && mem_addr == `CLKOUT_MODE_ADDR) begin
            en_ff   <= mem_wdata[3];
            seen_ff <= seen_ff | mem_wdata[3];
        end
    end
    // saturates so a long idle stretch never wraps back to zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            off_cnt_ff <= 8'h00;
        end else if (en_ff) begin
            off_cnt_ff <= 8'h00;
        end else if (off_cnt_ff != 8'hff) begin
            off_cnt_ff <= off_cnt_ff + 8'h01;
        end
    end
    read_hidden_a: assert property (mem_rdata == 4'h0) else $error("mode readable");
    oe_mode_a: assert property (port2_line2_oe == port2_line2_out_mode)
        else $error("oe differs from port mode");
    pin_mux_a: assert property (port2_line2_out == (port2_line2_latch | clock_out_pin))
        else $error("pin not latch or clock");
    high_width_a: assert property ($rose(clock_out_pin) |=> clock_out_pin)
        else $error("narrow high pulse");
    low_width_a: assert property ($fell(clock_out_pin) |=> !clock_out_pin)
        else $error("narrow low pulse");
    off_reset_a: assert property (clock_out_pin |-> seen_ff)
        else $error("clock out without enable");
    off_stop_a: assert property (off_cnt_ff >= 8'h8c |-> !clock_out_pin)
        else $error("clock out after disable");
    sub_delay_a: assert property ($rose(system_clock_control) && !cpu_on_subsystem
        |=> !cpu_on_subsystem [*8]) else $error("switch too early");
    sub_follow_a: assert property ($changed(cpu_on_subsystem)
        |-> cpu_on_subsystem == system_clock_control) else $error("switch unrequested");
endmodule : clkout_chk
bind clkout_gen clkout_chk u_chk (.clk(clk), .rst_b(rst_b), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .system_clock_control(system_clock_control), .cpu_on_subsystem(cpu_on_subsystem),
    .port2_line2_latch(port2_line2_latch), .port2_line2_out_mode(port2_line2_out_mode),
    .clock_out_pin(clock_out_pin), .port2_line2_out(port2_line2_out),
    .port2_line2_oe(port2_line2_oe));

/* File: verification/clkout_periph.sv */
// far side of the clock pin: a peripheral timing the pulses it receives
// assumes the line is pulled low while the port does not drive it
`timescale 1ns/1ns
module clkout_periph (
    // clock
    input  wire logic        clk,
    // pin from the device
    input  wire logic        pin_out,
    input  wire logic        pin_oe,
    // measurements
    output logic      [15:0] period,
    output logic      [15:0] high_width
);
    logic        line;
    logic        prev_ff    = 1'b0;
    logic [15:0] cnt_ff     = 16'h0000;
    logic [15:0] hcnt_ff    = 16'h0000;
    logic [15:0] period_ff  = 16'h0000;
    logic [15:0] high_ff    = 16'h0000;
    // ************************************************************
    // edge timing
    // ************************************************************
    assign line       = pin_oe & pin_out;
    assign period     = period_ff;
    assign high_width = high_ff;
    always @(posedge clk) begin
        prev_ff <= line;
        cnt_ff  <= cnt_ff + 16'h0001;
        hcnt_ff <= line ? hcnt_ff + 16'h0001 : 16'h0000;
        if (line && !prev_ff) begin
            period_ff <= cnt_ff;
            cnt_ff    <= 16'h0001;
        end
        if (!line && prev_ff) begin
            high_ff <= hcnt_ff;
        end
    end
endmodule : clkout_periph

/* File: verification/tb.sv */
// self-checking bench of the clock output generator
// assumes the main oscillator rate equal to clk (OSC_DIV 1) and a sub oscillator
// of 10 clocks
`timescale 1ns/1ns
`include "clkout_cfg.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic        clk, rst_b, mem_wr, mem_rd, sys_sel, latch, out_mode;
    logic [11:0] mem_addr;
    logic [3:0]  mem_wdata, mem_rdata;
    logic [1:0]  cpu_div;
    logic        cpu_clock, machine_cycle, cpu_on_subsystem, pin, p_out, p_oe;
    logic [15:0] per, hiw;
    logic        sub_osc = 1'b0;
    int          sub_cnt = 0;
    int          num_errors = 0;
    int          check_count = 0;
    int          mc_seen = 0;
    logic [1:0]  sel_tb [8] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    logic [1:0]  cpu_div_tb [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic        sys_sel_tb [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [15:0] per_tb [8] = '{16'h8, 16'h10, 16'h40, 16'h40, 16'h10, 16'h8, 16'h4, 16'h28};
    clkout_gen #(.OSC_DIV(1), .SWITCH_MC(4)) u_dut (.clk(clk), .rst_b(rst_b),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .processor_clock_control(cpu_div), .system_clock_control(sys_sel),
        .sub_osc_in(sub_osc), .cpu_clock(cpu_clock), .machine_cycle(machine_cycle),
        .cpu_on_subsystem(cpu_on_subsystem), .port2_line2_latch(latch),
        .port2_line2_out_mode(out_mode), .clock_out_pin(pin), .port2_line2_out(p_out),
        .port2_line2_oe(p_oe));
    clkout_periph u_periph (.clk(clk), .pin_out(p_out), .pin_oe(p_oe), .period(per),
        .high_width(hiw));
    // ************************************************************
    // clock, sub oscillator, bus tasks
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(negedge clk) begin
        sub_cnt <= (sub_cnt == 4) ? 0 : sub_cnt + 1;
        if (sub_cnt == 4) sub_osc <= ~sub_osc;
    end
    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        @(negedge clk);
        mem_addr  = a;
        mem_wdata = d;
        mem_wr    = 1'b1;
        @(negedge clk);
        mem_wr    = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(negedge clk);
        mem_addr = a;
        mem_rd   = 1'b1;
        @(negedge clk);
        mem_rd   = 1'b0;
        @(negedge clk);
        `CHK("rdata", 4'h0, mem_rdata)
    endtask : rd
    task automatic final_report;
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // ************************************************************
    // sequence and watchdog
    // ************************************************************
    initial begin
        repeat (15000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        {rst_b, mem_wr, mem_rd, sys_sel, out_mode, cpu_div} = 7'h0;
        {mem_addr, mem_wdata, latch} = 17'h1;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        rd(`CLKOUT_MODE_ADDR);
        `CHK("pin_reset", 1'b0, pin)
        wr(12'hfd1, 4'h8);
        // after reset the cpu runs at 1/64 of the oscillator: two cycles in any 128 clocks
        mc_seen = 0;
        repeat (128) begin
            @(negedge clk);
            if (machine_cycle) mc_seen++;
        end
        `CHK("mc_count", 2, mc_seen)
        `CHK("pin_unmapped", 1'b0, pin)
        for (int i = 0; i < 8; i++) begin
            wr(`CLKOUT_MODE_ADDR, {2'b00, sel_tb[i]});
            {cpu_div, sys_sel, latch} = {cpu_div_tb[i], sys_sel_tb[i], 1'b1};
            // long enough for the 4 machine cycle switchover even at 1/64 of the oscillator (256 clocks)
            repeat (600) @(negedge clk);
            `CHK("on_sub", sys_sel_tb[i], cpu_on_subsystem)
            {latch, out_mode} = 2'b01;
            wr(`CLKOUT_MODE_ADDR, {2'b10, sel_tb[i]});
            repeat (300) @(negedge clk);
            `CHK("period", per_tb[i], per)
            `CHK("high", per_tb[i] >> 1, hiw)
            wr(`CLKOUT_MODE_ADDR, {2'b00, sel_tb[i]});
            rd(`CLKOUT_MODE_ADDR);
            repeat (200) @(negedge clk);
            `CHK("pin_off", 1'b0, pin)
            out_mode = 1'b0;
        end
        final_report();
    end
endmodule : tb
